//--- hw/adccc_bus_if.sv
// Board register port between host and converter control.
// Assumes both ends share mclk; one access per sel, closed by ack.
`timescale 1ns/1ps
interface adccc_bus_if;
	logic        sel;
	logic        wr;
	logic [3:0]  addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        ack;

	modport dev (
		input  sel,
		input  wr,
		input  addr,
		input  wdata,
		output rdata,
		output ack
	);
	modport host (
		output sel,
		output wr,
		output addr,
		output wdata,
		input  rdata,
		input  ack
	);
endinterface : adccc_bus_if

//--- hw/adccc_defs.svh
// Offsets, field positions, reset values and timing counts of the
// converter control. Assumes a 100 MHz mclk.
`ifndef ADCCC_DEFS_SVH
`define ADCCC_DEFS_SVH

`define ADCCC_OFS_CTL      4'h2
`define ADCCC_OFS_RESULT   4'hc
`define ADCCC_OFS_GAIN     4'he

`define ADCCC_BIT_SETTLE   6
`define ADCCC_BIT_FRONT    7
`define ADCCC_MODE_LSB     8
`define ADCCC_MODE_MSB     10
`define ADCCC_BIT_FMT_N    12
`define ADCCC_BIT_CONV     13
`define ADCCC_BIT_RDY      15
`define ADCCC_MODE_ZERO    3'h0
`define ADCCC_MODE_DIFF    3'h1
`define ADCCC_MODE_SE      3'h2
`define ADCCC_STROBES      16'h2040

`define ADCCC_CTL_RST      16'h0000
`define ADCCC_GAIN_RST     2'h0
`define ADCCC_GAIN_UNITY   2'h0

`define ADCCC_CLK_NS       10
`define ADCCC_SETTLE_NS    11600
`define ADCCC_CONV_NS      16900
`define ADCCC_SETTLE_CYC \
	((`ADCCC_SETTLE_NS + `ADCCC_CLK_NS - 1) / `ADCCC_CLK_NS)
`define ADCCC_CONV_CYC \
	((`ADCCC_CONV_NS + `ADCCC_CLK_NS - 1) / `ADCCC_CLK_NS)

`define ADCCC_HOFS_CTRL    8'h00
`define ADCCC_HOFS_STATUS  8'h04
`define ADCCC_HOFS_RESULT  8'h08
`define ADCCC_HOFS_ISTAT   8'h0c
`define ADCCC_HOFS_IMASK   8'h10
`define ADCCC_HBIT_GO      31
`define ADCCC_HBIT_ILV     24

`endif

//--- hw/adccc_device.sv
// Converter control of the analog input board: control word, gain,
// settling and conversion timers, flags and result register.
// Assumes one 100 MHz clock and a converter sample held on sample.
`timescale 1ns/1ps
`include "adccc_defs.svh"

module adccc_device #(
	parameter int RES_W      = 12,
	parameter int SETTLE_CYC = `ADCCC_SETTLE_CYC,
	parameter int CONV_CYC   = `ADCCC_CONV_CYC
) (
	input  wire logic           mclk,
	input  wire logic           rst_n,
	adccc_bus_if.dev            bus,
	input  wire logic [RES_W-1:0] sample,
	output logic                front_connector_select,
	output logic [2:0]          mux_mode,
	output logic [4:0]          mux_channel,
	output logic [1:0]          gain_amplifier,
	output logic                channel_blocked,
	output logic                hold
);
	import adccc_pkg::*;

	generate
		if (RES_W < 2 || RES_W > 15)
			$error("adccc_device: RES_W must be 2 to 15");
		if (SETTLE_CYC < 1 || SETTLE_CYC > 65535)
			$error("adccc_device: SETTLE_CYC out of range");
		if (CONV_CYC < 1 || CONV_CYC > 65535)
			$error("adccc_device: CONV_CYC out of range");
	endgenerate

	localparam logic [15:0] SETTLE_LOAD = 16'(SETTLE_CYC - 1);
	localparam logic [15:0] CONV_LOAD   = 16'(CONV_CYC - 1);

	typedef struct packed {
		logic [15:0]      ctl;
		logic [1:0]       gain;
		logic [15:0]      result;
		logic             rdy;
		logic             settle_busy;
		logic             conv_busy;
		logic             conv_pend;
		logic [15:0]      scnt;
		logic [15:0]      ccnt;
		logic [RES_W-1:0] held;
		logic [15:0]      diff_used;
		logic             blocked;
		logic [4:0]       chan;
		logic             ack;
		logic [15:0]      rdata;
	} adccc_dev_t;

	adccc_dev_t s;
	adccc_dev_t next_s;

	// Offset binary in, optionally two's complement out
	function automatic logic [15:0] adccc_format(
		input logic [RES_W-1:0] raw,
		input logic             binary
	);
		logic [RES_W-1:0] v;
		v = raw;
		if (binary)
			return {{(16-RES_W){1'b0}}, raw};
		v[RES_W-1] = ~raw[RES_W-1];
		return {{(16-RES_W){v[RES_W-1]}}, v};
	endfunction : adccc_format

	logic       access;
	logic       wr_ctl;
	logic       wr_gain;
	logic       rd_result;
	logic       settle_go;
	logic       conv_go;
	logic       settle_end;
	logic       conv_start;
	logic       conv_end;
	logic [2:0] wmode;

	always_comb begin
		next_s     = s;
		access     = bus.sel & ~s.ack;
		wr_ctl     = access & bus.wr & (bus.addr == `ADCCC_OFS_CTL);
		wr_gain    = access & bus.wr & (bus.addr == `ADCCC_OFS_GAIN);
		rd_result  = access & ~bus.wr & (bus.addr == `ADCCC_OFS_RESULT);
		wmode      = bus.wdata[`ADCCC_MODE_MSB:`ADCCC_MODE_LSB];
		settle_go  = wr_ctl & bus.wdata[`ADCCC_BIT_SETTLE];
		conv_go    = wr_ctl & bus.wdata[`ADCCC_BIT_CONV];
		settle_end = s.settle_busy & (s.scnt == 16'h0000);
		conv_end   = s.conv_busy & (s.ccnt == 16'h0000);
		conv_start = (conv_go & ~settle_go & ~s.conv_busy)
			| (s.conv_pend & ~s.settle_busy & ~s.conv_busy);
		next_s.ack = access;

		if (wr_ctl)
			next_s.ctl = bus.wdata & ~`ADCCC_STROBES;
		if (wr_gain)
			next_s.gain = bus.wdata[1:0];

		// remember rear differential pairs in use
		if (wr_ctl && !bus.wdata[`ADCCC_BIT_FRONT]
				&& wmode == `ADCCC_MODE_DIFF)
			next_s.diff_used[bus.wdata[3:0]] = 1'b1;

		// timing made here, host only polls
		if (settle_go) begin
			next_s.settle_busy = 1'b1;
			next_s.scnt        = SETTLE_LOAD;
		end else if (settle_end) begin
			next_s.settle_busy = 1'b0;
		end else if (s.settle_busy) begin
			next_s.scnt = s.scnt - 16'h0001;
		end

		if (settle_go && conv_go)
			next_s.conv_pend = 1'b1;
		else if (conv_start)
			next_s.conv_pend = 1'b0;

		// settle plus convert paces basic use
		if (conv_start) begin
			next_s.conv_busy = 1'b1;
			next_s.ccnt      = CONV_LOAD;
			next_s.held      = sample;
		end else if (conv_end) begin
			next_s.conv_busy = 1'b0;
			next_s.result = adccc_format(s.held,
				s.ctl[`ADCCC_BIT_FMT_N]);
		end else if (s.conv_busy) begin
			next_s.ccnt = s.ccnt - 16'h0001;
		end

		// read clears ready; a new result wins
		if (conv_end)
			next_s.rdy = 1'b1;
		else if (rd_result)
			next_s.rdy = 1'b0;

		if (next_s.ctl[`ADCCC_BIT_FRONT]
				|| next_s.ctl[10:8] == `ADCCC_MODE_DIFF)
			next_s.chan = {1'b0, next_s.ctl[3:0]};
		else
			next_s.chan = next_s.ctl[4:0];
		// pins taken by a differential pair
		next_s.blocked = ~next_s.ctl[`ADCCC_BIT_FRONT]
			& (next_s.ctl[10:8] == `ADCCC_MODE_SE)
			& next_s.diff_used[next_s.ctl[3:0]];

		if (access && !bus.wr) begin
			case (bus.addr)
				`ADCCC_OFS_CTL: begin
					next_s.rdata = s.ctl;
					next_s.rdata[`ADCCC_BIT_SETTLE] = s.settle_busy;
					next_s.rdata[`ADCCC_BIT_CONV]   = s.conv_busy;
					next_s.rdata[14]                = 1'b0;
					next_s.rdata[`ADCCC_BIT_RDY]    = s.rdy;
				end
				`ADCCC_OFS_RESULT: next_s.rdata = s.result;
				`ADCCC_OFS_GAIN:   next_s.rdata = {14'h0000, s.gain};
				default:           next_s.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s      <= '0;
			s.ctl  <= `ADCCC_CTL_RST;
			s.gain <= `ADCCC_GAIN_RST;
		end else begin
			s <= next_s;
		end
	end

	assign bus.ack   = s.ack;
	assign bus.rdata = s.rdata;
	assign front_connector_select = s.ctl[`ADCCC_BIT_FRONT];
	// Blocked single-ended pins read as zeroed input, not a wrong pin
	assign mux_mode    = s.blocked ? `ADCCC_MODE_ZERO : s.ctl[10:8];
	assign mux_channel = s.chan;
	assign gain_amplifier  = s.gain;
	assign channel_blocked = s.blocked;
	assign hold            = s.conv_busy;

endmodule : adccc_device

//--- hw/adccc_host.sv
// Host end: APB registers for software, scan sequencer that drives
// the board register port with basic or interleaved handshakes.
// Assumes the device answers each access with one ack pulse.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "adccc_defs.svh"

module adccc_host (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	adccc_bus_if.host        bus
);
	import adccc_pkg::*;

	typedef struct packed {
		adccc_hstate_t st;
		logic [15:0]   base;
		logic [1:0]    gain;
		logic [4:0]    last;
		logic          ilv;
		logic [4:0]    cur;
		logic [4:0]    conv_ch;
		logic          pend;
		logic          fin;
		logic [15:0]   result;
		logic [4:0]    res_ch;
		logic [1:0]    ist;
		logic [1:0]    imask;
		logic          irq;
		logic [31:0]   prdata;
		logic          sel;
		logic          wr;
		logic [3:0]    addr;
		logic [15:0]   wdata;
	} adccc_host_t;

	adccc_host_t s;
	adccc_host_t next_s;

	function automatic logic [15:0] adccc_word(
		input logic [15:0] base,
		input logic [4:0]  ch,
		input logic [15:0] strobes
	);
		return {base[15:5], ch} & ~`ADCCC_STROBES | strobes;
	endfunction : adccc_word

	logic       wr_acc;
	logic       done;
	logic [1:0] ev;

	always_comb begin
		next_s = s;
		ev     = 2'b00;
		wr_acc = psel & penable & pwrite;
		done   = s.sel & bus.ack;

		if (psel && !penable && !pwrite) begin
			case (paddr)
				`ADCCC_HOFS_CTRL: next_s.prdata = {7'h00, s.ilv,
					1'b0, s.gain, s.last, s.base};
				`ADCCC_HOFS_STATUS: next_s.prdata = {19'h00000,
					s.cur, 3'h0, s.st != H_IDLE, s.st};
				`ADCCC_HOFS_RESULT: next_s.prdata = {11'h000,
					s.res_ch, s.result};
				`ADCCC_HOFS_ISTAT: next_s.prdata = {30'h0, s.ist};
				`ADCCC_HOFS_IMASK: next_s.prdata = {30'h0, s.imask};
				default: next_s.prdata = 32'h0000_0000;
			endcase
		end
		if (wr_acc && paddr == `ADCCC_HOFS_IMASK)
			next_s.imask = pwdata[1:0];
		// Go is ignored while a scan runs
		if (wr_acc && paddr == `ADCCC_HOFS_CTRL && s.st == H_IDLE) begin
			next_s.base = pwdata[15:0];
			next_s.last = pwdata[20:16];
			next_s.gain = pwdata[22:21];
			next_s.ilv  = pwdata[`ADCCC_HBIT_ILV];
			if (pwdata[`ADCCC_HBIT_GO]) begin
				next_s.cur  = pwdata[4:0];
				next_s.pend = 1'b0;
				next_s.fin  = 1'b0;
				next_s.st   = H_GAIN_ONE;
			end
		end

		if (s.st != H_IDLE && !s.sel) begin
			next_s.sel   = 1'b1;
			next_s.wr    = 1'b1;
			next_s.addr  = `ADCCC_OFS_CTL;
			next_s.wdata = adccc_word(s.base, s.cur, 16'h0000);
			case (s.st)
				H_GAIN_ONE: begin
					next_s.addr  = `ADCCC_OFS_GAIN;
					next_s.wdata = {14'h0000, `ADCCC_GAIN_UNITY};
				end
				H_GAIN_SET: begin
					next_s.addr  = `ADCCC_OFS_GAIN;
					next_s.wdata = {14'h0000, s.gain};
				end
				H_WR_BOTH: next_s.wdata = adccc_word(s.base, s.cur,
					`ADCCC_STROBES);
				H_WR_SET: next_s.wdata = adccc_word(s.base, s.cur,
					16'h0040);
				H_WR_CONV: next_s.wdata = adccc_word(s.base, s.cur,
					16'h2000);
				H_POLL_SET, H_POLL_RDY: next_s.wr = 1'b0;
				H_READ: begin
					next_s.wr   = 1'b0;
					next_s.addr = `ADCCC_OFS_RESULT;
				end
				default: next_s.wr = 1'b1;
			endcase
		end else if (done) begin
			next_s.sel = 1'b0;
			case (s.st)
				// gain never raised ahead of channel
				H_GAIN_ONE: next_s.st = H_SEL;
				H_SEL:      next_s.st = H_GAIN_SET;
				H_GAIN_SET: next_s.st = s.ilv ? H_WR_SET : H_WR_BOTH;
				H_WR_BOTH: begin
					next_s.conv_ch = s.cur;
					next_s.st      = H_POLL_RDY;
				end
				H_WR_SET: next_s.st = H_POLL_SET;
				// settle clear, then ready if pending
				H_POLL_SET: begin
					if (bus.rdata[`ADCCC_BIT_SETTLE])
						next_s.st = H_POLL_SET;
					else
						next_s.st = s.pend ? H_POLL_RDY : H_WR_CONV;
				end
				H_WR_CONV: begin
					next_s.conv_ch = s.cur;
					next_s.pend    = 1'b1;
					if (s.cur == s.last) begin
						next_s.fin = 1'b1;
						next_s.st  = H_POLL_RDY;
					end else begin
						next_s.cur = s.cur + 5'h01;
						next_s.st  = H_WR_SET;
					end
				end
				H_POLL_RDY: next_s.st = bus.rdata[`ADCCC_BIT_RDY]
					? H_READ : H_POLL_RDY;
				H_READ: begin
					next_s.result = bus.rdata;
					next_s.res_ch = s.conv_ch;
					next_s.pend   = 1'b0;
					ev[0]         = 1'b1;
					if (s.ilv && !s.fin) begin
						next_s.st = H_WR_CONV;
					end else if (s.ilv || s.cur == s.last) begin
						ev[1]     = 1'b1;
						next_s.st = H_IDLE;
					end else begin
						next_s.cur = s.cur + 5'h01;
						next_s.st  = H_WR_BOTH;
					end
				end
				default: next_s.st = H_IDLE;
			endcase
		end

		// Set wins over a write-one clear in the same cycle
		next_s.ist = s.ist | ev;
		if (wr_acc && paddr == `ADCCC_HOFS_ISTAT)
			next_s.ist = (s.ist & ~pwdata[1:0]) | ev;
		next_s.irq = |(next_s.ist & next_s.imask);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s    <= '0;
			s.st <= H_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign prdata    = s.prdata;
	assign pready    = 1'b1;
	assign pslverr   = 1'b0;
	assign irq       = s.irq;
	assign bus.sel   = s.sel;
	assign bus.wr    = s.wr;
	assign bus.addr  = s.addr;
	assign bus.wdata = s.wdata;

endmodule : adccc_host

//--- hw/adccc_pkg.sv
// State type of the host end of the converter control.
// Assumes adccc_defs.svh carries the numbers.
package adccc_pkg;

	typedef enum logic [3:0] {
		H_IDLE     = 4'h0,
		H_GAIN_ONE = 4'h1,
		H_SEL      = 4'h2,
		H_GAIN_SET = 4'h3,
		H_WR_BOTH  = 4'h4,
		H_WR_SET   = 4'h5,
		H_POLL_SET = 4'h6,
		H_WR_CONV  = 4'h7,
		H_POLL_RDY = 4'h8,
		H_READ     = 4'h9
	} adccc_hstate_t;

endpackage : adccc_pkg

//--- tb/adccc_bus_checker.sv
// Checker for the board register port between host and device ends.
// Assumes the port signals are wired in plainly, all on mclk.
`timescale 1ns/1ps
`include "adccc_defs.svh"
module adccc_bus_checker #(
	parameter int SETTLE_CYC = 8,
	parameter int CONV_CYC   = 12
) (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        sel,
	input wire logic        wr,
	input wire logic [3:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic        ack
);
	logic [15:0] ctl_w;
	int          cnt;
	logic        st_rd;
	logic        res_rd;
	logic        ctl_wr;
	logic        gain_wr;
	logic        prev_ctl;
	int          ccnt;

	assign st_rd   = ack && !wr && addr == `ADCCC_OFS_CTL;
	assign res_rd  = ack && !wr && addr == `ADCCC_OFS_RESULT;
	assign ctl_wr  = ack && wr && addr == `ADCCC_OFS_CTL;
	assign gain_wr = ack && wr && addr == `ADCCC_OFS_GAIN;

	// Shadow of the last control word; a margin covers read latency
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_w    <= `ADCCC_CTL_RST;
			cnt      <= 0;
			ccnt     <= 0;
			prev_ctl <= 1'b0;
		end else begin
			if (ctl_wr)
				ctl_w <= wdata;
			if (ack && wr)
				prev_ctl <= ctl_wr;
			// Convert write while busy is ignored, so no reload
			if (ctl_wr && wdata[`ADCCC_BIT_CONV]
					&& !wdata[`ADCCC_BIT_SETTLE] && ccnt == 0)
				ccnt <= CONV_CYC;
			else if (ccnt > 0)
				ccnt <= ccnt - 1;
			if (ctl_wr && wdata[`ADCCC_BIT_SETTLE])
				cnt <= SETTLE_CYC;
			else if (cnt > 0)
				cnt <= cnt - 1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	AST_ACK_PULSE:
		assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	AST_ACK_TIMING:
		assert property (sel && !ack |=> ack)
		else $error("ack not one cycle after request");
	AST_ACK_CAUSE:
		assert property ($rose(ack) |-> $past(sel))
		else $error("ack without request");
	AST_SEL_HOLD:
		assert property (sel && !ack |=> $stable(addr) && $stable(wr)
			&& $stable(wdata))
		else $error("request changed before ack");
	AST_SEL_DROP:
		assert property (ack |=> !sel)
		else $error("sel not dropped after ack");
	AST_FMT_EXT:
		assert property (res_rd |-> (ctl_w[`ADCCC_BIT_FMT_N]
			? rdata[15:12] == 4'h0 : rdata[15:12] == {4{rdata[11]}}))
		else $error("result upper bits wrong");
	AST_CTL_BACK:
		assert property (st_rd |-> rdata[12:7] == ctl_w[12:7]
			&& rdata[5:0] == ctl_w[5:0])
		else $error("control word readback wrong");
	AST_B14_ZERO:
		assert property (st_rd |-> !rdata[14])
		else $error("status bit 14 set");
	AST_SETTLE_BUSY:
		assert property (st_rd && cnt > 3 |-> rdata[`ADCCC_BIT_SETTLE])
		else $error("settle busy missing after strobe");
	AST_CONV_BUSY:
		assert property (st_rd && ccnt > 3 |-> rdata[`ADCCC_BIT_CONV])
		else $error("conversion busy missing after strobe");
	AST_GAIN_ORDER:
		assert property (gain_wr && wdata[1:0] != 2'h0 |-> prev_ctl)
		else $error("gain raised before channel select");

	cover property (ctl_wr && wdata[6] && wdata[13]);
	cover property (ctl_wr && wdata[6] && ccnt > 0);
	cover property (st_rd && rdata[6]);
	cover property (res_rd && !ctl_w[12]);
endmodule : adccc_bus_checker

//--- tb/tb_top.sv
// Bench joining host and device ends, driving software over APB.
// Assumes short settle and convert counts to keep the run brief.
`timescale 1ns/1ps
`include "adccc_defs.svh"
module tb_top;
	import adccc_pkg::*;
	localparam int SET_C = 8;
	localparam int CNV_C = 12;
	localparam int LIMIT = 40000;
	logic        mclk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [11:0] sample;
	logic        front_connector_select;
	logic [2:0]  mux_mode;
	logic [4:0]  mux_channel;
	logic [1:0]  gain_amplifier;
	logic        channel_blocked;
	logic        hold;
	logic [31:0] seed;
	logic [15:0] used;
	int          errors;
	int          n_compared;
	int          cycles;

	adccc_bus_if bus_if ();
	adccc_host adccc_host_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .bus(bus_if));
	adccc_device #(.RES_W(12), .SETTLE_CYC(SET_C), .CONV_CYC(CNV_C))
		adccc_device_inst (.mclk(mclk), .rst_n(rst_n), .bus(bus_if),
		.sample(sample), .front_connector_select(front_connector_select),
		.mux_mode(mux_mode), .mux_channel(mux_channel),
		.gain_amplifier(gain_amplifier), .channel_blocked(channel_blocked),
		.hold(hold));
	adccc_bus_checker #(.SETTLE_CYC(SET_C), .CONV_CYC(CNV_C))
		adccc_bus_checker_inst (
		.mclk(mclk), .rst_n(rst_n), .sel(bus_if.sel), .wr(bus_if.wr),
		.addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
		.ack(bus_if.ack));

	always #5 mclk = ~mclk;

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Binary keeps zeros above; signed flips the MSB and extends it
	function logic [15:0] res_exp(logic [11:0] s, logic fmt);
		logic [11:0] t;
		t = fmt ? s : s ^ 12'h800;
		return fmt ? {4'h0, t} : {{4{t[11]}}, t};
	endfunction : res_exp

	task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out

	task automatic apb(logic w, logic [7:0] a, logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic run_scan(logic front, logic [2:0] mode, logic [4:0] first,
		logic [4:0] last, logic ilv);
		logic [31:0] r;
		logic [31:0] ctl;
		logic        fmt;
		logic [1:0]  gain;
		logic        msk;
		logic        blk;
		int          n;
		int          t0;
		t0   = cycles;
		r    = rnd();
		fmt  = r[0];
		gain = r[2:1];
		msk  = r[3];
		sample <= r[15:4];
		ctl = {1'b1, 6'h0, ilv, 1'b0, gain, last,
			3'h0, fmt, 1'b0, mode, front, 2'h0, first};
		apb(1'b1, 8'h10, {30'h0, msk, 1'b0}, r);
		apb(1'b1, 8'h00, ctl, r);
		apb(1'b0, 8'h04, 32'h0, r);
		chk(r[4], 1'b1, "busy after go");
		apb(1'b1, 8'h00, {ctl[31:21], 5'h1f, ctl[15:0]}, r);
		n = 0;
		do begin
			apb(1'b0, 8'h04, 32'h0, r);
			n++;
		end while (r[4] !== 1'b0 && n < 500);
		chk(r[4:0], 5'h0, "idle after scan");
		chk(cycles - t0 <= (last - first + 1) * (SET_C + CNV_C + 24) + 40,
			1'b1, "pace");
		apb(1'b0, 8'h08, 32'h0, r);
		chk(r[20:0], {last, res_exp(sample, fmt)}, "result");
		apb(1'b0, 8'h00, 32'h0, r);
		chk(r, {1'b0, ctl[30:0]}, "ctrl kept");
		for (int c = first; c <= last; c++)
			if (!front && mode == 3'h1)
				used[c[3:0]] = 1'b1;
		blk = !front && mode == 3'h2 && used[last[3:0]];
		chk(channel_blocked, blk, "blocked");
		chk(mux_mode, blk ? 3'h0 : mode, "mode");
		chk(mux_channel, (front || mode == 3'h1) ? {1'b0, last[3:0]} : last,
			"channel");
		chk(front_connector_select, front, "connector");
		chk(gain_amplifier, gain, "gain");
		chk(hold, 1'b0, "hold idle");
		chk(irq, msk, "irq masked");
		apb(1'b0, 8'h0c, 32'h0, r);
		chk(r[1:0], 2'h3, "events");
		apb(1'b1, 8'h0c, 32'h3, r);
		apb(1'b0, 8'h0c, 32'h0, r);
		chk(r[1:0], 2'h0, "events cleared");
		chk(irq, 1'b0, "irq cleared");
		$display("scan %0d..%0d mode %0d done", first, last, mode);
	endtask : run_scan

	always @(posedge mclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			$display("[ERR] %0t timeout", $time);
			close_out();
		end
	end

	initial begin
		logic [31:0] r;
		logic [4:0]  f;
		mclk = 1'b0;
		rst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		sample = 12'h0;
		seed = 32'hecff86cd;
		used = 16'h0;
		errors = 0;
		n_compared = 0;
		cycles = 0;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		apb(1'b0, 8'h04, 32'h0, r);
		chk(r, 32'h0, "status at reset");
		chk({hold, channel_blocked, mux_mode, irq}, 6'h0,
			"outputs at reset");
		apb(1'b0, 8'h24, 32'h0, r);
		chk(pslverr, 1'b0, "unmapped read");
		chk(r, 32'h0, "unmapped read data");
		$display("reset checks done");
		run_scan(1'b1, 3'h1, 5'd9, 5'd10, 1'b0);
		run_scan(1'b0, 3'h1, 5'd2, 5'd4, 1'b1);
		run_scan(1'b0, 3'h2, 5'd7, 5'd8, 1'b0);
		run_scan(1'b0, 3'h2, 5'd17, 5'd18, 1'b1);
		for (int k = 0; k < 4; k++) begin
			r = rnd();
			f = r[4:0] % 5'd30;
			run_scan(1'b0, r[8] ? 3'h2 : 3'h1, f, f + {4'h0, r[9]}, r[10]);
		end
		close_out();
	end
endmodule : tb_top
